/* shared/tx_seq_pkg.sv */
/*
  Constants for the transmit frame sequencer: register map, field positions,
  reset values and timing. Assumes a 50 MHz core clock and a 32-bit APB bus.
*/
`default_nettype none
package tx_seq_pkg;
  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FILL   = 8'h0C;
  localparam logic [7:0] OFF_TXDATA = 8'h10;
  localparam logic [7:0] OFF_RXMASK = 8'h14;
  localparam logic [7:0] OFF_FCS    = 8'h18;
  localparam logic [7:0] OFF_FCF    = 8'h1C;
  // command bits
  localparam int CMD_TX_START    = 0;
  localparam int CMD_TX_IF_CLEAR = 1;
  localparam int CMD_RX_ON       = 2;
  localparam int CMD_RADIO_OFF   = 3;
  localparam int CMD_FLUSH       = 4;
  // control bits
  localparam int CTRL_AUTO_FCS   = 0;
  localparam int CTRL_RX_AFTER   = 1;
  localparam int CTRL_UF_IGNORE  = 2;
  localparam int CTRL_PRE_LSB    = 4;
  localparam int PRE_W           = 4;
  localparam logic [PRE_W-1:0] PRE_LEN_RST = 4'h4;
  localparam int RX_BIT_STROBE   = 15;
  localparam int RX_BIT_AFTER_TX = 14;
  // -------------------------------------------------------------------------
  // frame fields
  // -------------------------------------------------------------------------
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0]  SFD_BYTE      = 8'hA7;
  localparam logic [15:0] FCS_POLY_REV  = 16'h8408;
  localparam logic [15:0] FCS_INIT      = 16'h0000;
  localparam int FIFO_DEPTH   = 128;
  localparam int MIN_LEN_AUTO = 3;
  localparam int MIN_LEN_RAW  = 1;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int TURN_US      = 192;
  localparam int RAMP_US      = 2;
  localparam int BYTE_US      = 32;
  localparam int TURN_CYC     = TURN_US * CLK_MHZ;
  localparam int RAMP_CYC     = RAMP_US * CLK_MHZ;
  localparam int BYTE_CYC     = BYTE_US * CLK_MHZ;
  localparam int TIMER_W      = 14;
  typedef enum logic [3:0] {
    ST_IDLE, ST_TX_TURN, ST_PRE, ST_SFD, ST_LEN, ST_DATA, ST_FCS_LO, ST_FCS_HI,
    ST_RAMP, ST_RX_TURN, ST_RX_ON
  } radio_state_e;
endpackage : tx_seq_pkg
`default_nettype wire

/* hdl/tx_frame_sequencer.sv */
/*
  Transmit frame sequencer: command strobes, single-frame TX FIFO, preamble,
  delimiter, length-driven MPDU stream and optional hardware FCS.
  Assumes an APB master on pclk, a byte-serial modulator that takes one byte
  per tx_byte_stb, and clear_channel / copy / generic write ports on pclk.
*/
// Our own choices: the APB interface to the registers and the address map.
`default_nettype none
// Notes on behaviour
// RQ1 - frame control word fields decode from first two MPDU bytes
// RQ2 - two-byte FCS covers MPDU bytes only, after last payload byte
// RQ3 - FCS polynomial is x^16 + x^12 + x^5 + 1
// RQ4 - unconditional start begins transmission, latched clear flag untouched
// RQ5 - conditional start needs clear channel, aborts activity, latches flag
// RQ6 - receive-on strobe aborts transmission and enters receive calibration
// RQ7 - radio-off strobe aborts everything and forces idle
// RQ8 - with rx-after-tx set, unconditional start sets mask bit 14
// RQ9 - preamble starts 192 us after start; same delay back into receive
// RQ10 - ramp down 2 us after last byte or underflow; SFD and idle delayed; without auto FCS the code ramps one byte time later
// RQ11 - FIFO holds one frame up to 128 bytes; fill count readable
// RQ12 - writes start at location zero; generic writes need underflow-ignore
// RQ13 - flush empties FIFO; flushing mid-frame leads to underflow
// RQ14 - sent bytes stay so a new start resends the same frame
// RQ15 - first write after a finished frame flushes the old contents
// RQ16 - write when full raises overflow, drops byte, sticky until flush
// RQ17 - fetch from empty FIFO raises underflow and aborts, sticky till flush
// RQ18 - underflow-ignore suppresses underflow and sends stale bytes to length
// RQ19 - programmable preamble length then fixed one-byte delimiter
// RQ20 - length byte read after delimiter; minimum 3 with FCS, 1 without
// RQ21 - auto FCS held in own 16-bit register, else FCS taken from FIFO
// RQ22 - host writes length, header, payload; length counts the FCS bytes
// RQ23 - preamble bytes are 0x00, default four; delimiter is 0xA7
// RQ24 - frame-done event on success, delimiter event after delimiter
// RQ25 - FCS cleared per frame, updated LSB first per byte
// RQ26 - pending error blocks start strobes until flushed
module tx_frame_sequencer #(
  parameter int TURN_CYCLES = tx_seq_pkg::TURN_CYC,
  parameter int BYTE_CYCLES = tx_seq_pkg::BYTE_CYC
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        clear_channel,
  input  wire  logic        ram_to_tx_copy,
  input  wire  logic [7:0]  ram_copy_data,
  input  wire  logic        generic_mem_write,
  input  wire  logic [6:0]  generic_mem_addr,
  input  wire  logic [7:0]  generic_mem_data,
  output logic [7:0]        tx_byte,
  output logic              tx_byte_stb,
  output logic              sfd_active,
  output logic              tx_sfd_event,
  output logic              tx_frame_done_event,
  output logic              tx_overflow_event,
  output logic              tx_underflow_event,
  output logic              rx_cal_active,
  output logic [15:0]       rx_enable_mask
);
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  function automatic logic [15:0] fcs_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ tx_seq_pkg::FCS_POLY_REV; // [RQ3] [RQ25]
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : fcs_step

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : reg_hit

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  tx_seq_pkg::radio_state_e st_q, st_d;
  logic [7:0]   mem [tx_seq_pkg::FIFO_DEPTH];
  logic [7:0]   fill_q;
  logic         sent_q;
  logic         ovf_err_q, uf_err_q;
  logic [tx_seq_pkg::TIMER_W-1:0] cnt_q, cnt_d;
  logic [7:0]   idx_q, idx_d;
  logic [6:0]   len_q, len_d;
  logic [15:0]  fcs_q, fcs_d;
  logic [7:0]   byte_q, byte_d;
  logic         stb_q, stb_d;
  logic         sfd_q, sfd_d;
  logic         ev_sfd_q, ev_sfd_d, ev_done_q, ev_done_d, ev_uf_q, ev_uf_d, ev_ovf_q;
  logic         auto_q, rx_after_q, ign_q;
  logic [tx_seq_pkg::PRE_W-1:0] pre_len_q;
  logic [15:0]  mask_q;
  logic         latched_q;
  logic [31:0]  prdata_q;

  // -------------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------------
  wire acc      = psel && penable;
  wire wr_acc   = acc && pwrite;
  wire mapped   = reg_hit(paddr, tx_seq_pkg::OFF_CMD) || reg_hit(paddr, tx_seq_pkg::OFF_CTRL)
               || reg_hit(paddr, tx_seq_pkg::OFF_STATUS) || reg_hit(paddr, tx_seq_pkg::OFF_FILL)
               || reg_hit(paddr, tx_seq_pkg::OFF_TXDATA) || reg_hit(paddr, tx_seq_pkg::OFF_RXMASK)
               || reg_hit(paddr, tx_seq_pkg::OFF_FCS) || reg_hit(paddr, tx_seq_pkg::OFF_FCF);
  wire cmd_wr   = wr_acc && reg_hit(paddr, tx_seq_pkg::OFF_CMD);
  wire s_off    = cmd_wr && pwdata[tx_seq_pkg::CMD_RADIO_OFF];
  wire s_rxon   = cmd_wr && pwdata[tx_seq_pkg::CMD_RX_ON] && !s_off;
  wire s_cond   = cmd_wr && pwdata[tx_seq_pkg::CMD_TX_IF_CLEAR];
  wire s_start  = cmd_wr && pwdata[tx_seq_pkg::CMD_TX_START];
  wire s_flush  = cmd_wr && pwdata[tx_seq_pkg::CMD_FLUSH];
  wire err_any  = ovf_err_q || uf_err_q;
  wire go_cond  = s_cond && clear_channel && !err_any && !s_off && !s_rxon; // [RQ5] [RQ26]
  wire go_plain = s_start && !err_any && !s_off && !s_rxon;               // [RQ4] [RQ26]
  wire go_tx    = go_cond || go_plain;
  wire host_wr  = wr_acc && reg_hit(paddr, tx_seq_pkg::OFF_TXDATA);
  wire push     = host_wr || ram_to_tx_copy;
  wire [7:0] push_data = host_wr ? pwdata[7:0] : ram_copy_data;
  wire full     = fill_q == 8'(tx_seq_pkg::FIFO_DEPTH);
  wire push_ok  = push && !s_flush && (sent_q || !full);
  wire push_ovf = push && !s_flush && !sent_q && full;
  wire gen_ok   = generic_mem_write && ign_q && !s_flush;                  // [RQ12]

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_q;

  // frame control word view of the stored frame
  wire [15:0] fcf = {mem[2], mem[1]};
  wire [31:0] fcf_view = {16'h0000, fcf[15:14], fcf[11:10], 5'h00, fcf[6], fcf[5],
                          fcf[4], fcf[3], fcf[2:0]}; // [RQ1]

  wire [31:0] rd_mux =
      reg_hit(paddr, tx_seq_pkg::OFF_CTRL)   ? {24'h000000, pre_len_q, 1'b0, ign_q,
                                                rx_after_q, auto_q} :
      reg_hit(paddr, tx_seq_pkg::OFF_STATUS) ? {24'h000000, st_q, sent_q, uf_err_q,
                                                ovf_err_q, latched_q} :
      reg_hit(paddr, tx_seq_pkg::OFF_FILL)   ? {24'h000000, fill_q} : // [RQ11]
      reg_hit(paddr, tx_seq_pkg::OFF_RXMASK) ? {16'h0000, mask_q} :
      reg_hit(paddr, tx_seq_pkg::OFF_FCS)    ? {16'h0000, fcs_q} :
      reg_hit(paddr, tx_seq_pkg::OFF_FCF)    ? fcf_view : 32'h00000000;

  // -------------------------------------------------------------------------
  // settings, mask, clear flag, read data
  // -------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q     <= 1'b1;
      rx_after_q <= 1'b0;
      ign_q      <= 1'b0;
      pre_len_q  <= tx_seq_pkg::PRE_LEN_RST; // [RQ23]
      latched_q  <= 1'b0;
      prdata_q   <= 32'h00000000;
    end else begin
      if (wr_acc && reg_hit(paddr, tx_seq_pkg::OFF_CTRL)) begin
        auto_q     <= pwdata[tx_seq_pkg::CTRL_AUTO_FCS];
        rx_after_q <= pwdata[tx_seq_pkg::CTRL_RX_AFTER];
        ign_q      <= pwdata[tx_seq_pkg::CTRL_UF_IGNORE];
        pre_len_q  <= pwdata[tx_seq_pkg::CTRL_PRE_LSB +: tx_seq_pkg::PRE_W]; // [RQ19]
      end
      if (s_cond) begin
        latched_q <= clear_channel; // [RQ5]
      end
      if (psel && !penable) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 16'h0000;
    end else if (s_off) begin
      mask_q <= 16'h0000; // [RQ7]
    end else if (s_rxon) begin
      mask_q[tx_seq_pkg::RX_BIT_STROBE] <= 1'b1;
    end else if (wr_acc && reg_hit(paddr, tx_seq_pkg::OFF_RXMASK)) begin
      mask_q <= pwdata[15:0];
    end else if (go_plain && rx_after_q) begin
      mask_q[tx_seq_pkg::RX_BIT_AFTER_TX] <= 1'b1; // [RQ8]
    end
  end

  // -------------------------------------------------------------------------
  // FIFO storage and fill count
  // -------------------------------------------------------------------------
  // bytes are never popped: the read side only indexes, so a frame can resend
  always_ff @(posedge pclk) begin
    if (push_ok) begin
      mem[sent_q ? 7'h00 : fill_q[6:0]] <= push_data; // [RQ12] [RQ15]
    end else if (gen_ok) begin
      mem[generic_mem_addr] <= generic_mem_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q    <= 8'h00;
      sent_q    <= 1'b0;
      ovf_err_q <= 1'b0;
      ev_ovf_q  <= 1'b0;
    end else begin
      ev_ovf_q <= push_ovf; // [RQ16]
      if (s_flush) begin
        fill_q    <= 8'h00; // [RQ13]
        sent_q    <= 1'b0;
        ovf_err_q <= 1'b0;
      end else if (push_ok) begin
        fill_q <= sent_q ? 8'h01 : fill_q + 8'h01; // [RQ15]
        sent_q <= 1'b0;
      end else if (push_ovf) begin
        ovf_err_q <= 1'b1; // [RQ16]
      end else if (gen_ok && {1'b0, generic_mem_addr} >= fill_q) begin
        fill_q <= {1'b0, generic_mem_addr} + 8'h01;
      end else if (ev_done_d) begin
        sent_q <= 1'b1; // [RQ14]
      end
    end
  end

  // -------------------------------------------------------------------------
  // radio sequencer
  // -------------------------------------------------------------------------
  wire       tick      = cnt_q == '0;
  wire [7:0] data_last = auto_q ? {1'b0, len_q} - 8'h02 : {1'b0, len_q}; // [RQ21] [RQ22]
  wire       starved   = idx_q >= fill_q;
  wire       tx_busy   = st_q inside {tx_seq_pkg::ST_PRE, tx_seq_pkg::ST_SFD,
                                      tx_seq_pkg::ST_LEN, tx_seq_pkg::ST_DATA,
                                      tx_seq_pkg::ST_FCS_LO, tx_seq_pkg::ST_FCS_HI};
  localparam logic [tx_seq_pkg::TIMER_W-1:0] BYTE_RELOAD = tx_seq_pkg::TIMER_W'(BYTE_CYCLES - 1);
  localparam logic [tx_seq_pkg::TIMER_W-1:0] RAMP_RELOAD =
      tx_seq_pkg::TIMER_W'(tx_seq_pkg::RAMP_CYC - 1);
  localparam logic [tx_seq_pkg::TIMER_W-1:0] TAIL_RELOAD =
      tx_seq_pkg::TIMER_W'(BYTE_CYCLES + tx_seq_pkg::RAMP_CYC - 1);
  localparam logic [tx_seq_pkg::TIMER_W-1:0] TURN_RELOAD = tx_seq_pkg::TIMER_W'(TURN_CYCLES - 1);

  always_comb begin
    st_d      = st_q;
    cnt_d     = tick ? cnt_q : cnt_q - 1'b1;
    idx_d     = idx_q;
    len_d     = len_q;
    fcs_d     = fcs_q;
    byte_d    = byte_q;
    stb_d     = 1'b0;
    sfd_d     = sfd_q;
    ev_sfd_d  = 1'b0;
    ev_done_d = 1'b0;
    ev_uf_d   = 1'b0;
    if (s_off) begin
      st_d  = tx_seq_pkg::ST_IDLE; // [RQ7]
      sfd_d = 1'b0;
    end else if (s_rxon) begin
      st_d  = tx_seq_pkg::ST_RX_TURN; // [RQ6]
      cnt_d = TURN_RELOAD;
      sfd_d = 1'b0;
    end else if (go_tx) begin
      st_d  = tx_seq_pkg::ST_TX_TURN; // [RQ9]
      cnt_d = TURN_RELOAD;
      sfd_d = 1'b0;
    end else if (tick) begin
      case (st_q)
        tx_seq_pkg::ST_TX_TURN: begin
          st_d  = tx_seq_pkg::ST_PRE;
          idx_d = 8'h00;
        end
        tx_seq_pkg::ST_PRE: begin
          byte_d = tx_seq_pkg::PREAMBLE_BYTE; // [RQ19] [RQ23]
          stb_d  = 1'b1;
          cnt_d  = BYTE_RELOAD;
          idx_d  = idx_q + 8'h01;
          if (idx_q + 8'h01 >= {4'h0, pre_len_q}) begin
            st_d = tx_seq_pkg::ST_SFD;
          end
        end
        tx_seq_pkg::ST_SFD: begin
          byte_d   = tx_seq_pkg::SFD_BYTE; // [RQ23]
          stb_d    = 1'b1;
          cnt_d    = BYTE_RELOAD;
          sfd_d    = 1'b1;
          ev_sfd_d = 1'b1; // [RQ24]
          st_d     = tx_seq_pkg::ST_LEN;
        end
        tx_seq_pkg::ST_LEN: begin
          if (fill_q == 8'h00 && !ign_q) begin
            ev_uf_d = 1'b1; // [RQ17]
            st_d    = tx_seq_pkg::ST_RAMP;
            cnt_d   = RAMP_RELOAD;
          end else begin
            byte_d = mem[0]; // [RQ20]
            stb_d  = 1'b1;
            cnt_d  = BYTE_RELOAD;
            len_d  = mem[0][6:0];
            idx_d  = 8'h01;
            fcs_d  = tx_seq_pkg::FCS_INIT; // [RQ25]
            st_d   = tx_seq_pkg::ST_DATA;
          end
        end
        tx_seq_pkg::ST_DATA: begin
          if (idx_q > data_last || data_last[7]) begin
            // all data bytes sent, or length too short for the FCS: nothing left from the FIFO
            st_d  = auto_q ? tx_seq_pkg::ST_FCS_LO : tx_seq_pkg::ST_RAMP;
            cnt_d = auto_q ? cnt_q : TAIL_RELOAD;
            ev_done_d = !auto_q;
          end else if (starved && !ign_q) begin
            ev_uf_d = 1'b1; // [RQ17] [RQ13]
            st_d    = tx_seq_pkg::ST_RAMP;
            cnt_d   = RAMP_RELOAD;
          end else begin
            byte_d = mem[idx_q[6:0]]; // [RQ18]
            stb_d  = 1'b1;
            cnt_d  = BYTE_RELOAD;
            fcs_d  = fcs_step(fcs_q, mem[idx_q[6:0]]); // [RQ2]
            idx_d  = idx_q + 8'h01;
          end
        end
        tx_seq_pkg::ST_FCS_LO: begin
          byte_d = fcs_q[7:0]; // [RQ21]
          stb_d  = 1'b1;
          cnt_d  = BYTE_RELOAD;
          st_d   = tx_seq_pkg::ST_FCS_HI;
        end
        tx_seq_pkg::ST_FCS_HI: begin
          byte_d    = fcs_q[15:8];
          stb_d     = 1'b1;
          cnt_d     = TAIL_RELOAD;
          ev_done_d = 1'b1; // [RQ24]
          st_d      = tx_seq_pkg::ST_RAMP;
        end
        tx_seq_pkg::ST_RAMP: begin
          sfd_d = 1'b0; // [RQ10]
          if (mask_q != 16'h0000) begin
            st_d  = tx_seq_pkg::ST_RX_TURN; // [RQ9]
            cnt_d = TURN_RELOAD;
          end else begin
            st_d = tx_seq_pkg::ST_IDLE;
          end
        end
        tx_seq_pkg::ST_RX_TURN: begin
          st_d = tx_seq_pkg::ST_RX_ON;
        end
        tx_seq_pkg::ST_IDLE, tx_seq_pkg::ST_RX_ON: begin
          st_d = st_q;
        end
        default: begin
          st_d = tx_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= tx_seq_pkg::ST_IDLE;
      cnt_q    <= '0;
      idx_q    <= 8'h00;
      len_q    <= 7'h00;
      fcs_q    <= tx_seq_pkg::FCS_INIT;
      byte_q   <= 8'h00;
      stb_q    <= 1'b0;
      sfd_q    <= 1'b0;
      ev_sfd_q <= 1'b0;
      ev_done_q <= 1'b0;
      ev_uf_q  <= 1'b0;
      uf_err_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      idx_q     <= idx_d;
      len_q     <= len_d;
      fcs_q     <= fcs_d;
      byte_q    <= byte_d;
      stb_q     <= stb_d;
      sfd_q     <= sfd_d;
      ev_sfd_q  <= ev_sfd_d;
      ev_done_q <= ev_done_d;
      ev_uf_q   <= ev_uf_d;
      // a new underflow in the flush cycle still counts
      uf_err_q  <= ev_uf_d || (uf_err_q && !s_flush); // [RQ17]
    end
  end

  assign tx_byte             = byte_q;
  assign tx_byte_stb         = stb_q;
  assign sfd_active          = sfd_q;
  assign tx_sfd_event        = ev_sfd_q;
  assign tx_frame_done_event = ev_done_q;
  assign tx_overflow_event   = ev_ovf_q;
  assign tx_underflow_event  = ev_uf_q;
  assign rx_cal_active       = st_q == tx_seq_pkg::ST_RX_TURN;
  assign rx_enable_mask      = mask_q;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  logic [tx_seq_pkg::TIMER_W-1:0] turn_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      turn_seen_q <= '0;
    end else if (st_q == tx_seq_pkg::ST_TX_TURN) begin
      turn_seen_q <= turn_seen_q + 1'b1;
    end else begin
      turn_seen_q <= '0;
    end
  end

  AST_TURN_TIME: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
    (st_q == tx_seq_pkg::ST_TX_TURN && st_d == tx_seq_pkg::ST_PRE)
      |-> turn_seen_q == tx_seq_pkg::TIMER_W'(TURN_CYCLES - 1))
    else $error("turnaround length wrong");
  AST_SFD_BYTE: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
    $rose(tx_sfd_event) |-> tx_byte == 8'hA7 && sfd_active && tx_byte_stb)
    else $error("delimiter byte or flag wrong");
  AST_OVF_DROP: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
    push_ovf |=> tx_overflow_event && fill_q == 8'h80 && ovf_err_q)
    else $error("overflow not raised or byte stored");
  AST_UF_ABORT: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
    tx_underflow_event |-> st_q == tx_seq_pkg::ST_RAMP && uf_err_q && !tx_byte_stb)
    else $error("underflow did not abort");
  AST_UF_IGNORED: assert property (@(posedge pclk) disable iff (!presetn) // [RQ18]
    ign_q && $past(ign_q) |-> !tx_underflow_event)
    else $error("underflow raised while ignored");
  AST_FLUSH_EMPTY: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    s_flush |=> fill_q == 8'h00 && !ovf_err_q)
    else $error("flush left data or error");
  AST_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
    s_off |=> st_q == tx_seq_pkg::ST_IDLE && rx_enable_mask == 16'h0000 && !sfd_active)
    else $error("radio off did not idle");
  AST_RXON_CAL: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
    s_rxon |=> rx_cal_active && rx_enable_mask[15])
    else $error("receive on did not calibrate");
  AST_ERR_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn) // [RQ26]
    (err_any && (s_start || s_cond) && !s_rxon && !s_off && st_q != tx_seq_pkg::ST_TX_TURN)
      |=> st_q != tx_seq_pkg::ST_TX_TURN)
    else $error("start accepted with pending error");
  AST_PLAIN_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
    (s_start && !s_cond) |=> $stable(latched_q))
    else $error("clear flag changed on plain start");
  AST_SFD_STRETCH: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    $fell(sfd_active) && $past(st_q) == tx_seq_pkg::ST_RAMP
      && !$past(s_off || s_rxon || go_tx) |-> $past(cnt_q) == '0)
    else $error("delimiter flag dropped early");

  COV_DONE: cover property (@(posedge pclk) disable iff (!presetn) tx_frame_done_event);
  COV_UF: cover property (@(posedge pclk) disable iff (!presetn) tx_underflow_event);
  COV_OVF: cover property (@(posedge pclk) disable iff (!presetn) tx_overflow_event);
  COV_RESEND: cover property (@(posedge pclk) disable iff (!presetn)
    sent_q && go_tx);
  COV_FLUSH_MID: cover property (@(posedge pclk) disable iff (!presetn) s_flush && tx_busy);
endmodule : tx_frame_sequencer
`default_nettype wire

/* bench/host_model.sv */
/* host side: apb master tasks and clear-channel level.
   assumes the sequencer as slave on the same clock. */
`default_nettype none
module host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             clear_channel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------------
  // apb transfer
  // ---------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    clear_channel = 1'b1;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : host_model
`default_nettype wire

/* bench/tb_tx_frame_sequencer.sv */
/* bench for tx_frame_sequencer: host model drives apb, monitor checks bytes.
   assumes short turnaround and byte spacing parameters. */
`default_nettype none
module tb_tx_frame_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cc, stb, done_ev;
  logic        sfd_ev, ovf_ev, uf_ev, cp, gw;
  logic [7:0]  paddr, tx_byte, cpd, gd;
  logic [6:0]  ga;
  logic [31:0] pwdata, prdata;
  logic [8:0]  exp_q[$];
  int          n_ev = 0;
  logic [7:0]  fr[4];
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  tx_frame_sequencer #(.TURN_CYCLES(20), .BYTE_CYCLES(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_channel(cc), .ram_to_tx_copy(cp), .ram_copy_data(cpd),
    .generic_mem_write(gw), .generic_mem_addr(ga), .generic_mem_data(gd),
    .tx_byte(tx_byte), .tx_byte_stb(stb), .sfd_active(), .tx_sfd_event(sfd_ev),
    .tx_frame_done_event(done_ev), .tx_overflow_event(ovf_ev), .tx_underflow_event(uf_ev),
    .rx_cal_active(), .rx_enable_mask());
  host_model host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .clear_channel(cc));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ---------------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // a strobe with nothing queued can never match
  always @(negedge pclk) if (stb === 1'b1) cmp({sfd_ev, tx_byte}, exp_q.size() ? exp_q.pop_front() : '1);
  always @(negedge pclk) n_ev += {ovf_ev, uf_ev};
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 16'h8408 : 16'h0000);
    return c;
  endfunction : crc
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    logic        er;
    host_u.xfer(1'b0, a, 32'h0, r, er);
    cmp(r & m, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    host_u.xfer(1'b1, a, d, r, er);
  endtask : wr
  task automatic send(input logic [31:0] cmd);
    logic [15:0] c;
    int          k;
    c = 16'h0000;
    k = 0;
    repeat (4) exp_q.push_back(8'h00);
    exp_q.push_back(9'h1A7);
    foreach (fr[i]) exp_q.push_back(fr[i]);
    for (int i = 1; i < 4; i++) c = crc(c, fr[i]);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
    wr(tx_seq_pkg::OFF_CMD, cmd);
    while (done_ev !== 1'b1 && k < 2000) begin
      @(negedge pclk);
      k++;
    end
    cmp(k < 2000, 1);
  endtask : send
  initial begin
    presetn = 1'b0;
    {cp, cpd, gw, ga, gd} <= '0;
    void'($urandom(38));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(tx_seq_pkg::OFF_FILL, 32'hFF, 32'h00);
    rd(tx_seq_pkg::OFF_CTRL, 32'hF7, 32'h41);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    fr[0] = 8'h05; // length counts the two fcs bytes
    for (int i = 1; i < 4; i++) fr[i] = 8'($urandom);
    wr(tx_seq_pkg::OFF_CTRL, 32'h43);
    foreach (fr[i]) wr(tx_seq_pkg::OFF_TXDATA, {24'h0, fr[i]});
    rd(tx_seq_pkg::OFF_FILL, 32'hFF, 32'h04);
    rd(tx_seq_pkg::OFF_FCF, 32'hFFFF, {fr[2][7:6], fr[2][3:2], 5'h0, fr[1][6:0]});
    send(32'h1);
    repeat (120) @(posedge pclk);
    rd(tx_seq_pkg::OFF_RXMASK, 32'hFFFF, 32'h4000);
    send(32'h2);
    rd(tx_seq_pkg::OFF_STATUS, 32'h01, 32'h01);
    wr(tx_seq_pkg::OFF_CMD, 32'h08);
    rd(tx_seq_pkg::OFF_STATUS, 32'hF0, 32'h00);
    for (int i = 0; i < 128; i++) wr(tx_seq_pkg::OFF_TXDATA, 32'($urandom) & 32'hFF);
    rd(tx_seq_pkg::OFF_FILL, 32'hFF, 32'h80);
    wr(tx_seq_pkg::OFF_TXDATA, 32'h5A);
    rd(tx_seq_pkg::OFF_STATUS, 32'h02, 32'h02);
    wr(tx_seq_pkg::OFF_CMD, 32'h01);
    repeat (60) @(posedge pclk); // any strobe here fails in the monitor
    wr(tx_seq_pkg::OFF_CMD, 32'h10);
    rd(tx_seq_pkg::OFF_FILL, 32'hFF, 32'h00);
    rd(tx_seq_pkg::OFF_STATUS, 32'h06, 32'h00);
    repeat (4) exp_q.push_back(9'h000);
    exp_q.push_back(9'h1A7);
    wr(tx_seq_pkg::OFF_CMD, 32'h01);
    repeat (80) @(posedge pclk);
    wr(tx_seq_pkg::OFF_CMD, 32'h14);
    wr(tx_seq_pkg::OFF_CTRL, 32'h44);
    @(posedge pclk) {cp, cpd} <= {1'b1, 8'($urandom)};
    @(posedge pclk) {cp, gw, ga} <= {2'b01, 7'h05};
    @(posedge pclk) gw <= 1'b0;
    rd(tx_seq_pkg::OFF_FILL, 32'hFF, 32'h06);
    cmp(n_ev, 3);
    report_and_stop();
  end
endmodule : tb_tx_frame_sequencer
`default_nettype wire
